// >>> core/motor_pwm_pkg.sv
// shared constants for the motor pwm timer set: register map, control bits, reset values
package motor_pwm_pkg;

    // apb geometry
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;

    // timer numbering and channel allotment
    localparam int          NUM_TMR      = 3;
    localparam int          NUM_CH       = 9;
    localparam int          NUM_DT       = 7;
    localparam logic [1:0]  TMR_ADV      = 2'h0;
    localparam logic [1:0]  TMR_GEN      = 2'h1;
    localparam logic [1:0]  TMR_RED      = 2'h2;
    localparam logic [1:0]  TMR_GLOBAL   = 2'h3;
    localparam logic [3:0]  ADV_CH_NUM   = 4'h3;
    localparam logic [3:0]  GEN_CH_NUM   = 4'h4;
    localparam logic [3:0]  RED_CH_NUM   = 4'h2;
    localparam logic [3:0]  ADV_CH_BASE  = 4'h0;
    localparam logic [3:0]  GEN_CH_BASE  = 4'h3;
    localparam logic [3:0]  RED_CH_BASE  = 4'h7;

    // register offsets inside each timer's 64-byte block
    localparam logic [5:0]  REG_CTRL     = 6'h00;
    localparam logic [5:0]  REG_PSC      = 6'h04;
    localparam logic [5:0]  REG_ARR      = 6'h08;
    localparam logic [5:0]  REG_REP      = 6'h0C;
    localparam logic [5:0]  REG_CCMODE   = 6'h10;
    localparam logic [3:0]  REG_CCR_IDX  = 4'h5;
    localparam logic [5:0]  REG_DTG      = 6'h24;
    localparam logic [5:0]  REG_CNT      = 6'h28;
    // global block (timer slot 3)
    localparam logic [5:0]  REG_STATUS   = 6'h00;
    localparam logic [5:0]  REG_MASK     = 6'h04;

    // control register bits
    localparam int          CTRL_EN      = 0;
    localparam int          CTRL_DIR     = 1;
    localparam int          CTRL_OPM     = 2;
    localparam int          CTRL_MOE     = 3;
    localparam int          CTRL_COMP    = 4;
    localparam int          CTRL_LRST    = 5;
    localparam int          CTRL_LGATE   = 6;
    localparam int          CTRL_DMA     = 7;
    localparam int          CTRL_BRK     = 8;
    localparam int          CCMODE_CSEL  = 8;

    // channel modes, two bits per channel in the mode register
    localparam logic [1:0]  MODE_CMP     = 2'h0;
    localparam logic [1:0]  MODE_PWM     = 2'h1;
    localparam logic [1:0]  MODE_CAP     = 2'h2;

    // status bit positions
    localparam int          ST_UPD       = 0;
    localparam int          ST_CAP       = 3;
    localparam int          ST_BRK       = 9;
    localparam int          ST_W         = 10;

    // synchroniser lanes: 0..3 general pins, 4..5 reduced pins, 6 comparator, 7 brake pin
    localparam int          SYN_W        = 8;
    localparam int          SYN_CMP      = 6;
    localparam int          SYN_BRK      = 7;

    // values after reset
    localparam logic [15:0] RST_ARR      = 16'hFFFF;
    localparam logic [15:0] RST_ZERO16   = 16'h0000;
endpackage

// >>> core/timer_counter.sv
// one 16-bit up/down counter with prescaler, repetition count, one-pulse stop and link inputs
`timescale 1ns/100ps
module timer_counter (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        enable,
    input  wire logic        dir_down,
    input  wire logic        one_pulse,
    input  wire logic [15:0] psc,
    input  wire logic [15:0] arr,
    input  wire logic [15:0] rep,
    input  wire logic        ext_reset,
    input  wire logic        gate,
    output logic      [15:0] cnt,
    output logic             update,
    output logic             running
);
    logic [15:0] pre;
    logic [15:0] rep_left;
    logic        stopped;
    logic        tick;
    logic        wrap;

    // counting stops while gated by the master or after a one-pulse period
    assign running = enable & ~stopped & gate;
    assign tick    = running & (pre == psc);
    assign wrap    = tick & (dir_down ? (cnt == 16'h0000) : (cnt == arr));

    // prescaler divides the system clock by psc+1
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pre <= 16'h0000;
        end else if (!running || ext_reset || tick) begin
            pre <= 16'h0000; // [R1]
        end else begin
            pre <= pre + 16'h0001;
        end
    end

    // main counter: up to arr then zero, or down to zero then arr
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 16'h0000;
        end else if (ext_reset) begin
            cnt <= dir_down ? arr : 16'h0000; // [R5]
        end else if (tick) begin
            if (dir_down) begin
                cnt <= (cnt == 16'h0000) ? arr : cnt - 16'h0001; // [R1] [R15]
            end else begin
                cnt <= (cnt == arr) ? 16'h0000 : cnt + 16'h0001; // [R1] [R15]
            end
        end
    end

    // repetition count: first update after one period, then one every rep+1 periods
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rep_left <= 16'h0000;
            update   <= 1'b0;
        end else begin
            update <= wrap & (rep_left == 16'h0000); // [R3] [R15]
            if (wrap) begin
                rep_left <= (rep_left == 16'h0000) ? rep : rep_left - 16'h0001; // [R3]
            end
        end
    end

    // one-pulse mode halts on the update; dropping enable re-arms it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stopped <= 1'b0;
        end else if (!enable) begin
            stopped <= 1'b0;
        end else if (wrap && rep_left == 16'h0000 && one_pulse) begin
            stopped <= 1'b1; // [R7]
        end
    end
endmodule

// >>> core/motor_pwm_timer_set.sv
// advanced, general and reduced pwm timers behind an apb register slave
//
// Overview of operation
// R1 - advanced timer: 16-bit up/down counter, prescaler
// R2 - advanced timer: three complementary pairs with dead time
// R3 - repetition count delays the update event
// R4 - comparator trip forces pwm into brake state
// R5 - timers linkable for sync and triggers
// R6 - general timer: 16-bit counter, four channels
// R7 - channels: capture, compare, pwm, one-pulse (capture on general and reduced channels only, advanced channels have none)
// R8 - general ch1/ch2 complements on ch3/ch4 pins
// R9 - reduced timer: 16-bit counter, two channels
// R10 - reduced channels full modes plus simple dead time
// R11 - comparator selectable as general capture trigger
// R12 - advanced and general timers raise dma requests
// R13 - timers provide adc start triggers
// R14 - dead time holds both pair outputs inactive
// R15 - counter reload issues maskable update event
`timescale 1ns/100ps
module motor_pwm_timer_set (
    input  wire logic        CLK_SYS,
    input  wire logic        NRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [3:0]  GEN_CH_IN,
    input  wire logic [1:0]  RED_CH_IN,
    input  wire logic        CURRENT_COMPARATOR,
    input  wire logic        BRAKE_INPUT,
    output logic      [2:0]  ADV_PWM_HI,
    output logic      [2:0]  ADV_PWM_LO,
    output logic      [3:0]  GEN_CH_OUT,
    output logic      [1:0]  RED_CH_OUT,
    output logic             IRQ,
    output logic      [1:0]  DMA_REQ,
    output logic      [2:0]  ADC_TRIG
);
    // timer that owns channel i: 0..2 advanced, 3..6 general, 7..8 reduced
    function automatic logic [1:0] timer_of(input int i);
        if (i < int'(motor_pwm_pkg::GEN_CH_BASE)) begin
            return motor_pwm_pkg::TMR_ADV;
        end else if (i < int'(motor_pwm_pkg::RED_CH_BASE)) begin
            return motor_pwm_pkg::TMR_GEN;
        end
        return motor_pwm_pkg::TMR_RED;
    endfunction

    // first channel index of a timer
    function automatic logic [3:0] ch_base(input logic [1:0] t);
        case (t)
            motor_pwm_pkg::TMR_ADV: return motor_pwm_pkg::ADV_CH_BASE;
            motor_pwm_pkg::TMR_GEN: return motor_pwm_pkg::GEN_CH_BASE;
            default:                return motor_pwm_pkg::RED_CH_BASE;
        endcase
    endfunction

    // number of compare registers a timer has
    function automatic logic [3:0] ch_num(input logic [1:0] t);
        case (t)
            motor_pwm_pkg::TMR_ADV: return motor_pwm_pkg::ADV_CH_NUM;
            motor_pwm_pkg::TMR_GEN: return motor_pwm_pkg::GEN_CH_NUM;
            default:                return motor_pwm_pkg::RED_CH_NUM;
        endcase
    endfunction

    logic [15:0] ctrl     [motor_pwm_pkg::NUM_TMR];
    logic [15:0] psc      [motor_pwm_pkg::NUM_TMR];
    logic [15:0] arr      [motor_pwm_pkg::NUM_TMR];
    logic [15:0] rep      [motor_pwm_pkg::NUM_TMR];
    logic [15:0] ccmode   [motor_pwm_pkg::NUM_TMR];
    logic [7:0]  dtg      [motor_pwm_pkg::NUM_TMR];
    logic [15:0] cnt      [motor_pwm_pkg::NUM_TMR];
    logic [15:0] cnt_prev [motor_pwm_pkg::NUM_TMR];
    logic [15:0] ccr      [motor_pwm_pkg::NUM_CH];
    logic [1:0]  mode     [motor_pwm_pkg::NUM_CH];
    logic [7:0]  dcnt     [motor_pwm_pkg::NUM_DT];
    logic [2:0]  upd;
    logic [2:0]  run;
    logic [2:0]  ext_rst;
    logic [2:0]  gate;
    logic [8:0]  tog;
    logic [8:0]  ch_ref;
    logic [8:0]  cap_evt;
    logic [6:0]  dref;
    logic [6:0]  hi_act;
    logic [6:0]  lo_act;
    logic [7:0]  syn_a;
    logic [7:0]  syn_b;
    logic [7:0]  syn_c;
    logic [9:0]  status;
    logic [9:0]  mask;
    logic [9:0]  evt;
    logic        brake;
    logic        trip;
    logic        setup;
    logic        wr;
    logic        rd_done;
    logic        hit_ok;
    logic        is_ccr;
    logic [3:0]  ccr_k;
    logic [3:0]  ccr_i;
    logic [31:0] rd_val;
    logic [1:0]  sel_t;
    logic [5:0]  sel_r;

    // pins and the comparator are asynchronous: two flops, then a third for edges
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            syn_a <= 8'h00;
            syn_b <= 8'h00;
            syn_c <= 8'h00;
        end else begin
            syn_a <= {BRAKE_INPUT, CURRENT_COMPARATOR, RED_CH_IN, GEN_CH_IN};
            syn_b <= syn_a;
            syn_c <= syn_b;
        end
    end

    // three identical counters; general follows advanced, reduced follows general
    generate
        for (genvar t = 0; t < motor_pwm_pkg::NUM_TMR; t++) begin : g_tmr
            if (t == 0) begin : g_master
                assign ext_rst[t] = 1'b0;
                assign gate[t]    = 1'b1;
            end else begin : g_slave
                assign ext_rst[t] = ctrl[t][motor_pwm_pkg::CTRL_LRST] & upd[t-1]; // [R5]
                assign gate[t]    = ~ctrl[t][motor_pwm_pkg::CTRL_LGATE] | run[t-1]; // [R5]
            end
            timer_counter u_cnt (
                .clk       (CLK_SYS),
                .nrst      (NRST),
                .enable    (ctrl[t][motor_pwm_pkg::CTRL_EN]),
                .dir_down  (ctrl[t][motor_pwm_pkg::CTRL_DIR]),
                .one_pulse (ctrl[t][motor_pwm_pkg::CTRL_OPM]),
                .psc       (psc[t]),
                .arr       (arr[t]),
                .rep       (rep[t]),
                .ext_reset (ext_rst[t]),
                .gate      (gate[t]),
                .cnt       (cnt[t]),
                .update    (upd[t]),
                .running   (run[t])
            ); // [R1] [R6] [R9]
        end
    endgenerate

    // apb decode: timer slot in the top two address bits, register below
    always_comb begin
        sel_t  = PADDR[7:6];
        sel_r  = PADDR[5:0];
        ccr_k  = PADDR[5:2] - motor_pwm_pkg::REG_CCR_IDX;
        is_ccr = (sel_t != motor_pwm_pkg::TMR_GLOBAL) && (PADDR[5:2] >= motor_pwm_pkg::REG_CCR_IDX)
                 && (ccr_k < ch_num(sel_t)) && (PADDR[1:0] == 2'h0);
        ccr_i  = ch_base(sel_t) + ccr_k;
        hit_ok = 1'b1;
        rd_val = 32'h0000_0000;
        if (PADDR[1:0] != 2'h0) begin
            hit_ok = 1'b0;
        end else if (sel_t == motor_pwm_pkg::TMR_GLOBAL) begin
            case (sel_r)
                motor_pwm_pkg::REG_STATUS: rd_val = {22'h000000, status};
                motor_pwm_pkg::REG_MASK:   rd_val = {22'h000000, mask};
                default:                   hit_ok = 1'b0;
            endcase
        end else if (is_ccr) begin
            rd_val = {16'h0000, ccr[ccr_i]};
        end else begin
            case (sel_r)
                motor_pwm_pkg::REG_CTRL:   rd_val = {16'h0000, ctrl[sel_t]};
                motor_pwm_pkg::REG_PSC:    rd_val = {16'h0000, psc[sel_t]};
                motor_pwm_pkg::REG_ARR:    rd_val = {16'h0000, arr[sel_t]};
                motor_pwm_pkg::REG_REP:    rd_val = {16'h0000, rep[sel_t]};
                motor_pwm_pkg::REG_CCMODE: rd_val = {16'h0000, ccmode[sel_t]};
                motor_pwm_pkg::REG_DTG:    rd_val = {24'h000000, dtg[sel_t]};
                motor_pwm_pkg::REG_CNT:    rd_val = {16'h0000, cnt[sel_t]};
                default:                   hit_ok = 1'b0;
            endcase
        end
    end

    assign setup   = PSEL & ~PENABLE;
    assign wr      = PSEL & PENABLE & PREADY & PWRITE & hit_ok;
    assign rd_done = PSEL & PENABLE & PREADY & ~PWRITE & hit_ok;

    // no wait state: data and ready prepared in the setup cycle, so the first access edge completes
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= setup;
            PSLVERR <= setup & ~hit_ok;
            if (setup) begin
                PRDATA <= PWRITE ? 32'h0000_0000 : rd_val;
            end
        end
    end

    // per-timer configuration registers
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            for (int t = 0; t < motor_pwm_pkg::NUM_TMR; t++) begin
                ctrl[t]   <= motor_pwm_pkg::RST_ZERO16;
                psc[t]    <= motor_pwm_pkg::RST_ZERO16;
                arr[t]    <= motor_pwm_pkg::RST_ARR;
                rep[t]    <= motor_pwm_pkg::RST_ZERO16;
                ccmode[t] <= motor_pwm_pkg::RST_ZERO16;
                dtg[t]    <= 8'h00;
            end
        end else if (wr && sel_t != motor_pwm_pkg::TMR_GLOBAL && !is_ccr) begin
            case (sel_r)
                motor_pwm_pkg::REG_CTRL:   ctrl[sel_t]   <= PWDATA[15:0];
                motor_pwm_pkg::REG_PSC:    psc[sel_t]    <= PWDATA[15:0];
                motor_pwm_pkg::REG_ARR:    arr[sel_t]    <= PWDATA[15:0];
                motor_pwm_pkg::REG_REP:    rep[sel_t]    <= PWDATA[15:0]; // [R3]
                motor_pwm_pkg::REG_CCMODE: ccmode[sel_t] <= PWDATA[15:0];
                motor_pwm_pkg::REG_DTG:    dtg[sel_t]    <= PWDATA[7:0];
                default:                   ;
            endcase
        end
    end

    // per-channel mode, and capture edges from pin or comparator
    always_comb begin
        for (int i = 0; i < motor_pwm_pkg::NUM_CH; i++) begin
            mode[i] = ccmode[timer_of(i)][2*(i - int'(ch_base(timer_of(i)))) +: 2];
        end
        cap_evt = 9'h000;
        for (int i = int'(motor_pwm_pkg::GEN_CH_BASE); i < motor_pwm_pkg::NUM_CH; i++) begin
            if (i < int'(motor_pwm_pkg::RED_CH_BASE)
                    && ccmode[motor_pwm_pkg::TMR_GEN][motor_pwm_pkg::CCMODE_CSEL + i - 3]) begin
                cap_evt[i] = syn_b[motor_pwm_pkg::SYN_CMP] & ~syn_c[motor_pwm_pkg::SYN_CMP]; // [R11]
            end else begin
                cap_evt[i] = syn_b[i - 3] & ~syn_c[i - 3]; // [R7] [R10]
            end
            cap_evt[i] = cap_evt[i] & (mode[i] == motor_pwm_pkg::MODE_CAP);
        end
    end

    // compare registers: a capture on the same edge as a write wins, as it is newer
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            for (int i = 0; i < motor_pwm_pkg::NUM_CH; i++) begin
                ccr[i] <= motor_pwm_pkg::RST_ZERO16;
            end
        end else begin
            for (int i = 0; i < motor_pwm_pkg::NUM_CH; i++) begin
                if (cap_evt[i]) begin
                    ccr[i] <= cnt[timer_of(i)]; // [R7]
                end else if (wr && is_ccr && ccr_i == 4'(i)) begin
                    ccr[i] <= PWDATA[15:0];
                end
            end
        end
    end

    // toggle-on-match needs the count to move, so a stopped timer does not chatter
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            tog <= 9'h000;
            for (int t = 0; t < motor_pwm_pkg::NUM_TMR; t++) begin
                cnt_prev[t] <= motor_pwm_pkg::RST_ZERO16;
            end
        end else begin
            for (int t = 0; t < motor_pwm_pkg::NUM_TMR; t++) begin
                cnt_prev[t] <= cnt[t];
            end
            for (int i = 0; i < motor_pwm_pkg::NUM_CH; i++) begin
                if (mode[i] == motor_pwm_pkg::MODE_CMP && cnt[timer_of(i)] == ccr[i]
                        && cnt[timer_of(i)] != cnt_prev[timer_of(i)]) begin
                    tog[i] <= ~tog[i]; // [R7]
                end
            end
        end
    end

    // reference level per channel; pwm is low while the counter is halted
    always_comb begin
        for (int i = 0; i < motor_pwm_pkg::NUM_CH; i++) begin
            case (mode[i])
                motor_pwm_pkg::MODE_PWM: ch_ref[i] = run[timer_of(i)] & (cnt[timer_of(i)] < ccr[i]); // [R2] [R7]
                motor_pwm_pkg::MODE_CMP: ch_ref[i] = tog[i];
                default:                 ch_ref[i] = 1'b0;
            endcase
        end
    end

    // dead-time units: 0..2 advanced pairs, 3..4 general ch1/ch2, 5..6 reduced channels
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            dref <= 7'h00;
            for (int d = 0; d < motor_pwm_pkg::NUM_DT; d++) begin
                dcnt[d] <= 8'h00;
            end
        end else begin
            for (int d = 0; d < motor_pwm_pkg::NUM_DT; d++) begin
                if (dref[d] != ch_ref[(d < 5) ? d : d + 2]) begin
                    dref[d] <= ch_ref[(d < 5) ? d : d + 2];
                    dcnt[d] <= dtg[timer_of((d < 5) ? d : d + 2)]; // [R2] [R8] [R10]
                end else if (dcnt[d] != 8'h00) begin
                    dcnt[d] <= dcnt[d] - 8'h01;
                end
            end
        end
    end

    // both sides stay off until the dead interval has run out
    always_comb begin
        for (int d = 0; d < motor_pwm_pkg::NUM_DT; d++) begin
            hi_act[d] = dref[d] & (dcnt[d] == 8'h00); // [R14]
            lo_act[d] = ~dref[d] & (dcnt[d] == 8'h00); // [R14]
        end
    end

    // brake: comparator or brake pin; latched so a trip cannot glitch back into drive
    assign trip = ctrl[motor_pwm_pkg::TMR_ADV][motor_pwm_pkg::CTRL_BRK]
                  & (syn_b[motor_pwm_pkg::SYN_CMP] | syn_b[motor_pwm_pkg::SYN_BRK]);

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            brake <= 1'b0;
        end else if (trip) begin
            brake <= 1'b1; // [R4]
        end else if (wr && sel_t == motor_pwm_pkg::TMR_ADV && sel_r == motor_pwm_pkg::REG_CTRL
                     && PWDATA[motor_pwm_pkg::CTRL_MOE]) begin
            brake <= 1'b0;
        end
    end

    // pin drivers, all registered; brake forces every advanced output low
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            ADV_PWM_HI <= 3'h0;
            ADV_PWM_LO <= 3'h0;
            GEN_CH_OUT <= 4'h0;
            RED_CH_OUT <= 2'h0;
        end else begin
            if (ctrl[motor_pwm_pkg::TMR_ADV][motor_pwm_pkg::CTRL_MOE] && !brake) begin
                ADV_PWM_HI <= hi_act[2:0]; // [R2]
                ADV_PWM_LO <= lo_act[2:0]; // [R2]
            end else begin
                ADV_PWM_HI <= 3'h0; // [R4]
                ADV_PWM_LO <= 3'h0; // [R4]
            end
            if (ctrl[motor_pwm_pkg::TMR_GEN][motor_pwm_pkg::CTRL_COMP]) begin
                GEN_CH_OUT <= {lo_act[4], lo_act[3], hi_act[4], hi_act[3]}; // [R8]
            end else begin
                GEN_CH_OUT <= ch_ref[6:3];
            end
            RED_CH_OUT <= hi_act[6:5]; // [R10]
        end
    end

    // dma requests and adc start triggers are one-cycle pulses on the update event
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            DMA_REQ  <= 2'h0;
            ADC_TRIG <= 3'h0;
        end else begin
            DMA_REQ  <= {upd[1] & ctrl[motor_pwm_pkg::TMR_GEN][motor_pwm_pkg::CTRL_DMA],
                         upd[0] & ctrl[motor_pwm_pkg::TMR_ADV][motor_pwm_pkg::CTRL_DMA]}; // [R12]
            ADC_TRIG <= upd; // [R13]
        end
    end

    // event vector: updates, general and reduced captures, brake onset
    always_comb begin
        evt = 10'h000;
        evt[motor_pwm_pkg::ST_UPD +: 3] = upd; // [R15]
        evt[motor_pwm_pkg::ST_CAP +: 6] = cap_evt[8:3];
        evt[motor_pwm_pkg::ST_BRK]      = trip & ~brake;
    end

    // sticky status cleared by reading it; an event in the clearing cycle survives
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            status <= 10'h000;
            mask   <= 10'h000;
        end else begin
            if (rd_done && sel_t == motor_pwm_pkg::TMR_GLOBAL && sel_r == motor_pwm_pkg::REG_STATUS) begin
                status <= evt;
            end else begin
                status <= status | evt;
            end
            if (wr && sel_t == motor_pwm_pkg::TMR_GLOBAL && sel_r == motor_pwm_pkg::REG_MASK) begin
                mask <= PWDATA[9:0];
            end
        end
    end

    // level interrupt, one cycle behind the status bits
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(status & mask); // [R15]
        end
    end
endmodule

// >>> test/motor_pwm_asserts.sv
// checker for the apb handshake, pwm leg overlap and event pulses
`timescale 1ns/100ps
module motor_pwm_asserts (
    input wire logic        CLK_SYS,
    input wire logic        NRST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [2:0]  ADV_PWM_HI,
    input wire logic [2:0]  ADV_PWM_LO,
    input wire logic [1:0]  DMA_REQ,
    input wire logic [2:0]  ADC_TRIG
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    // one bus transfer is a setup step then a single access step
    sequence s_setup; PSEL && !PENABLE; endsequence
    sequence s_access; PSEL && PENABLE && PREADY; endsequence
    a_ready_follows: assert property (s_setup |=> s_access)
        else $error("ready missing after setup");
    a_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_err_in_access: assert property (PSLVERR |-> s_access)
        else $error("error outside access");
    a_err_read_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
        else $error("refused read not zero");
    a_no_shoot: assert property ((ADV_PWM_HI & ADV_PWM_LO) == 3'h0)
        else $error("both drives of a leg on");
    a_dma_pulse: assert property (DMA_REQ[0] |=> !DMA_REQ[0])
        else $error("dma request held");
    a_dma_on_update: assert property (DMA_REQ[0] |-> ADC_TRIG[0])
        else $error("dma request without update");
    a_trig_pulse: assert property (ADC_TRIG[0] |=> !ADC_TRIG[0])
        else $error("adc trigger held");
endmodule

// >>> test/gate_driver_model.sv
// gate driver stand-in: counts shoot-through cycles and high-side turn-ons
`timescale 1ns/100ps
module gate_driver_model (
    input wire logic       clk,
    input wire logic [2:0] hi,
    input wire logic [2:0] lo,
    output int             overlaps,
    output int             rises
);
    logic [2:0] hi_q;
    initial begin
        overlaps = 0;
        rises = 0;
        hi_q = 3'h0;
    end
    // both gates of a leg on would short the bridge supply
    always @(posedge clk) begin
        if ((hi & lo) !== 3'h0) overlaps <= overlaps + 1;
        if ((hi & ~hi_q) !== 3'h0) rises <= rises + 1;
        hi_q <= hi;
    end
endmodule

// >>> test/motor_pwm_timer_set_tb.sv
// testbench for the motor pwm timer set
`timescale 1ns/100ps
module motor_pwm_timer_set_tb;
    logic        CLK_SYS, NRST, PSEL, PENABLE, PWRITE, CURRENT_COMPARATOR, PREADY, PSLVERR, IRQ, er;
    logic        BRAKE_INPUT = 1'b0;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [3:0]  GEN_CH_IN = 4'h0, GEN_CH_OUT;
    logic [1:0]  RED_CH_IN = 2'h0, RED_CH_OUT, DMA_REQ;
    logic [2:0]  ADV_PWM_HI, ADV_PWM_LO, ADC_TRIG;
    int          fails = 0, checks = 0, n, overlaps, rises;
    motor_pwm_timer_set u_motor_pwm_timer_set (.*);
    gate_driver_model u_gate_driver_model (.clk(CLK_SYS), .hi(ADV_PWM_HI), .lo(ADV_PWM_LO),
        .overlaps(overlaps), .rises(rises));
    initial begin
        CLK_SYS = 1'b0;
        forever #12.5 CLK_SYS = ~CLK_SYS;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; waits on pready, the watchdog bounds a hang
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do @(posedge CLK_SYS); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task tally_and_finish;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #250000;
        fails++;
        tally_and_finish;
    end
    initial begin
        {NRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA, CURRENT_COMPARATOR} = '0;
        repeat (5) @(posedge CLK_SYS);
        NRST <= 1'b1;
        apb(0, 8'h08, 0); chk(rd, 32'h0000FFFF);
        apb(0, 8'h40, 0); chk(rd, 32'h0);
        apb(0, 8'h2C, 0); chk({er, rd[30:0]}, 32'h80000000);
        apb(1, 8'h01, 1); chk(er, 1'b1);
        $display("test registers done");
        // adv: psc 1, arr 3, rep 1, ch1 pwm at 2, dead time 1, update unmasked
        apb(1, 8'h04, 1); apb(1, 8'h08, 3); apb(1, 8'h0C, 1); apb(1, 8'h10, 1);
        apb(1, 8'h14, 2); apb(1, 8'h24, 1); apb(1, 8'hC4, 1); apb(1, 8'h00, 32'h89);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin @(posedge CLK_SYS); n++; end while (ADC_TRIG[0] !== 1'b1 && n < 200);
        end
        chk(n, 32'd16);
        chk(DMA_REQ, 2'h1);
        chk(IRQ, 1'b1);
        apb(0, 8'hC0, 0); chk(rd[0], 1'b1);
        $display("test period done");
        // one comparator trip both brakes adv and captures on gen ch1
        // gen runs with ch1/ch2 complementary, so idle refs show on the ch3/ch4 pins
        apb(1, 8'h40, 32'h11); apb(1, 8'h50, 32'h102); apb(1, 8'h00, 32'h189);
        CURRENT_COMPARATOR <= 1'b1;
        repeat (4) @(posedge CLK_SYS);
        CURRENT_COMPARATOR <= 1'b0;
        repeat (6) @(posedge CLK_SYS);
        chk(ADV_PWM_HI | ADV_PWM_LO, 3'h0);
        chk(GEN_CH_OUT, 4'hC);
        apb(0, 8'hC0, 0); chk(rd & 32'h208, 32'h208);
        apb(1, 8'hC4, 0); apb(0, 8'hC0, 0);
        repeat (2) @(posedge CLK_SYS);
        chk(IRQ, 1'b0);
        chk(overlaps, 32'd0);
        chk(rises > 0, 1'b1);
        $display("test brake done");
        // reduced: arr 3, one-pulse; one period gives one update and one toggle on match
        apb(1, 8'h88, 3); apb(1, 8'h80, 5);
        n = 0;
        repeat (40) begin @(posedge CLK_SYS); n += ADC_TRIG[2]; end
        chk(n, 32'd1);
        chk(RED_CH_OUT, 2'h3);
        $display("test one-pulse done");
        tally_and_finish;
    end
endmodule
bind motor_pwm_timer_set motor_pwm_asserts u_motor_pwm_asserts (.*);
